// ==== design/pmw_ctrl.sv ====
`timescale 1ns/100ps
`include "pmw_defs.svh"
module pmw_ctrl #(
  parameter int IO_W = 8,
  parameter int CYC_SHDN = `PMW_CYC_SHDN,
  parameter int CYC_STBY = `PMW_CYC_STBY
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pmw_pkg::pmw_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // asynchronous wake and status pins
  input wire logic reset_pin_n,
  input wire logic [IO_W-1:0] io_pin_in,
  input wire logic rtc_event,
  input wire logic sc_event,
  input wire logic int_event,
  input wire logic bod_low,
  input wire logic fast_clk_stable,
  // io latch
  input wire logic [IO_W-1:0] io_core_out,
  output logic [IO_W-1:0] io_pin_out,
  output logic io_latch_en,
  // power and clock gates
  output logic cpu_clk_en,
  output logic mem_clk_en,
  output logic periph_clk_en,
  output logic radio_clk_en,
  output logic flash_pwr_en,
  output logic always_on_domain_en,
  output logic sensor_ctl_en,
  output logic fast_clk_en,
  output logic fast_crystal_osc_sel,
  output logic slow_crystal_osc_sel,
  output logic slow_clk_out_en,
  output logic brown_out_detector_en,
  output logic core_reset_n,
  output logic active_reached
);
  import pmw_pkg::*;

  // 14 bits hold the longest wake count at 100 ns
  localparam int CNT_W = 14;
  localparam int CYC_IDLE = `PMW_CYC_IDLE;
  localparam int CYC_STAB = `PMW_CYC_CLK_STABLE;

  pmw_state_e state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] wake_len_ff;
  logic from_reset_ff;
  logic [2:0] ctrl_ff;
  logic [`PMW_IRQ_W-1:0] stat_ff, mask_ff;
  logic [1:0] rcause_ff;
  logic [2:0] clk_ff;
  logic [IO_W-1:0] wake_cfg_ff;
  logic [IO_W-1:0] latch_ff;
  logic bod_lock_ff;

  // two-flop synchronisers for every pin-side input
  // reset pin bit starts at its idle high level; a low start would
  // drive every power-on boot through the held state
  logic [IO_W+5:0] sync1_ff, sync2_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= {1'b1, {(IO_W+5){1'b0}}};
      sync2_ff <= {1'b1, {(IO_W+5){1'b0}}};
    end else begin
      sync1_ff <= {reset_pin_n, io_pin_in, rtc_event, sc_event, int_event, bod_low,
        fast_clk_stable};
      sync2_ff <= sync1_ff;
    end
  end
  logic rst_pin_n_s, rtc_s, sc_s, int_s, bod_s, stable_s;
  logic [IO_W-1:0] io_s;
  assign {rst_pin_n_s, io_s, rtc_s, sc_s, int_s, bod_s, stable_s} = sync2_ff;

  // previous synchronised io for level-change detection
  // starts low like the sync flops, so reset release shows no change
  logic [IO_W-1:0] io_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_prev_ff <= '0;
    end else begin
      io_prev_ff <= io_s;
    end
  end
  logic pin_change;
  assign pin_change = |((io_s ^ io_prev_ff) & wake_cfg_ff);

  // apb decode; always ready, one access cycle
  // no wait states: every readable value already sits in a flop
  logic wr, rd;
  logic addr_ok;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      `PMW_OFF_CTRL, `PMW_OFF_MODE, `PMW_OFF_STAT, `PMW_OFF_MASK,
      `PMW_OFF_RCAUSE, `PMW_OFF_CLK, `PMW_OFF_WCFG: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // read data muxed from flops; stands through the access phase
  always_comb begin
    case (paddr)
      `PMW_OFF_CTRL: prdata = {29'h0, ctrl_ff};
      `PMW_OFF_MODE: prdata = {29'h0, state_ff};
      `PMW_OFF_STAT: prdata = {26'h0, stat_ff};
      `PMW_OFF_MASK: prdata = {26'h0, mask_ff};
      `PMW_OFF_RCAUSE: prdata = {30'h0, rcause_ff};
      `PMW_OFF_CLK: prdata = {29'h0, clk_ff};
      `PMW_OFF_WCFG: prdata = {{(32-IO_W){1'b0}}, wake_cfg_ff};
      default: prdata = 32'h0;
    endcase
  end

  // software-written config; all but the wake pin enables lost through shutdown since core reset reloads it
  // go only acts in active; the sequencer drops it elsewhere
  logic go;
  assign go = wr && paddr == `PMW_OFF_CTRL && pwdata[`PMW_CTRL_GO_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 3'h0;
      mask_ff <= '0;
      clk_ff <= `PMW_CLK_RST;
      wake_cfg_ff <= '0;
    end else if (state_ff == PMW_SHDN || state_ff == PMW_HELD) begin
      // registers lost
      // wake pin enables kept, else only the reset pin could end a shutdown
      ctrl_ff <= 3'h0;
      mask_ff <= '0;
      clk_ff <= `PMW_CLK_RST;
    end else if (wr) begin
      if (paddr == `PMW_OFF_CTRL) ctrl_ff <= {1'b0, pwdata[1:0]};
      if (paddr == `PMW_OFF_MASK) mask_ff <= pwdata[`PMW_IRQ_W-1:0];
      if (paddr == `PMW_OFF_CLK) clk_ff <= pwdata[2:0];
      if (paddr == `PMW_OFF_WCFG) wake_cfg_ff <= pwdata[IO_W-1:0];
    end
  end

  // wake event qualification per mode
  // the interrupt line alone never ends standby or shutdown
  logic wake_idle, wake_stby;
  assign wake_idle = int_s | rtc_s | sc_s | pin_change;
  // sensor wakes cpu only via its configured event
  assign wake_stby = rtc_s | sc_s | pin_change;

  // mode sequencer
  // active leaves only on a go write or a held reset pin
  // every sleep mode returns through wake, never straight to active
  // held reset overrides all, so the reset pin always wins
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PMW_ACTIVE: begin
        if (go) begin
          case (pwdata[1:0])
            `PMW_REQ_IDLE: nxt_state = PMW_IDLE;
            // software must avoid standby on weak supply
            `PMW_REQ_STBY: nxt_state = PMW_STBY;
            `PMW_REQ_SHDN: nxt_state = PMW_SHDN;
            default: nxt_state = PMW_ACTIVE;
          endcase
        end
      end
      PMW_IDLE: if (wake_idle) nxt_state = PMW_WAKE;
      PMW_STBY: if (wake_stby) nxt_state = PMW_WAKE;
      // pin change acts as reset trigger
      PMW_SHDN: if (pin_change) nxt_state = PMW_WAKE;
      PMW_HELD: nxt_state = PMW_WAKE;
      PMW_WAKE: begin
        if (cnt_ff >= wake_len_ff && !bod_lock_ff) nxt_state = PMW_ACTIVE;
      end
      default: nxt_state = PMW_ACTIVE;
    endcase
    // reset pin wakes from every mode
    if (!rst_pin_n_s) nxt_state = PMW_HELD;
  end

  // counts assume a 100 ns pclk; another clock needs new parameters
  // wake length chosen on entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= PMW_WAKE;
      cnt_ff <= '0;
      wake_len_ff <= CNT_W'(CYC_SHDN);
      from_reset_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      // counter rearms only on entry, so a late event cannot restart a wake
      if (nxt_state == PMW_WAKE && state_ff != PMW_WAKE) begin
        cnt_ff <= '0;
        from_reset_ff <= state_ff == PMW_SHDN || state_ff == PMW_HELD;
        case (state_ff)
          PMW_IDLE: wake_len_ff <= CNT_W'(CYC_IDLE);
          PMW_STBY: wake_len_ff <= CNT_W'(CYC_STBY);
          default: wake_len_ff <= CNT_W'(CYC_SHDN);
        endcase
      end else if (state_ff == PMW_WAKE && cnt_ff < wake_len_ff) begin
        // hold count until fast clock stable past stabilise point
        if (cnt_ff < CNT_W'(CYC_STAB) || stable_s) cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // held pin wins over a shutdown wake in the same cycle
  // reset cause capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcause_ff <= `PMW_RC_POR;
    end else if (state_ff == PMW_HELD) begin
      rcause_ff <= `PMW_RC_PIN;
    end else if (state_ff == PMW_SHDN && nxt_state == PMW_WAKE) begin
      rcause_ff <= `PMW_RC_SHDN_WAKE;
    end
  end

  // no register write frees the lock; a device on a sagging supply stays put
  // brown-out lock, sampled in standby gaps, cleared only by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bod_lock_ff <= 1'b0;
    end else if (state_ff == PMW_HELD) begin
      bod_lock_ff <= 1'b0;
    end else if (state_ff == PMW_STBY && bod_s) begin
      bod_lock_ff <= 1'b1;
    end
  end

  // io latch: capture on entry to standby or shutdown, hold meanwhile
  // core values tracked only in active, so the last active value is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_ff <= '0;
    end else if (state_ff == PMW_ACTIVE) begin
      latch_ff <= io_core_out;
    end
  end
  logic latched;
  assign latched = state_ff == PMW_STBY || state_ff == PMW_SHDN ||
    (state_ff == PMW_WAKE && from_reset_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_pin_out <= '0;
      io_latch_en <= 1'b0;
    end else begin
      io_latch_en <= latched;
      io_pin_out <= latched ? latch_ff : io_core_out;
    end
  end

  // interrupt status; set beats write-one-clear
  // wake causes logged only outside active, where they mean a wake
  logic [`PMW_IRQ_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[`PMW_IRQ_ACTIVE] = state_ff == PMW_WAKE && nxt_state == PMW_ACTIVE;
    ev[`PMW_IRQ_WAKE_PIN] = pin_change && state_ff != PMW_ACTIVE;
    ev[`PMW_IRQ_WAKE_RTC] = rtc_s && (state_ff == PMW_IDLE || state_ff == PMW_STBY);
    ev[`PMW_IRQ_WAKE_SC] = sc_s && (state_ff == PMW_IDLE || state_ff == PMW_STBY);
    ev[`PMW_IRQ_WAKE_INT] = int_s && state_ff == PMW_IDLE;
    ev[`PMW_IRQ_BOD_LOCK] = state_ff == PMW_STBY && bod_s && !bod_lock_ff;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= '0;
    end else if (state_ff == PMW_SHDN || state_ff == PMW_HELD) begin
      // old status lost; the waking event still lands
      stat_ff <= ev;
    end else if (wr && paddr == `PMW_OFF_STAT) begin
      stat_ff <= (stat_ff & ~pwdata[`PMW_IRQ_W-1:0]) | ev;
    end else begin
      stat_ff <= stat_ff | ev;
    end
  end
  // irq from flops only, so a clear takes it low at once
  assign irq = |(stat_ff & mask_ff);

  // gates derived from mode
  // every gate is a flop, so no gate glitches while the state settles
  logic run, wake_late;
  assign run = state_ff == PMW_ACTIVE;
  assign wake_late = state_ff == PMW_WAKE && cnt_ff >= CNT_W'(CYC_STAB) && stable_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b0;
      mem_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      radio_clk_en <= 1'b0;
      flash_pwr_en <= 1'b0;
      always_on_domain_en <= 1'b1;
      sensor_ctl_en <= 1'b0;
      fast_clk_en <= 1'b0;
      core_reset_n <= 1'b0;
      active_reached <= 1'b0;
      brown_out_detector_en <= 1'b0;
    end else begin
      // active runs all; cpu clock only once wake is done
      cpu_clk_en <= run;
      mem_clk_en <= run;
      active_reached <= run;
      periph_clk_en <= run || state_ff == PMW_IDLE;
      radio_clk_en <= run || state_ff == PMW_IDLE;
      flash_pwr_en <= run || state_ff == PMW_IDLE || wake_late;
      always_on_domain_en <= state_ff != PMW_SHDN && state_ff != PMW_HELD;
      sensor_ctl_en <= state_ff == PMW_ACTIVE || state_ff == PMW_IDLE ||
        state_ff == PMW_STBY;
      // supply and fast clock up first during wake
      fast_clk_en <= run || state_ff == PMW_IDLE || state_ff == PMW_WAKE;
      // standby and idle wakes skip reset
      core_reset_n <= !(state_ff == PMW_HELD || state_ff == PMW_SHDN ||
        (state_ff == PMW_WAKE && from_reset_ff && !wake_late));
      // detector duty cycled: off in standby gaps
      brown_out_detector_en <= run || state_ff == PMW_IDLE || state_ff == PMW_WAKE;
    end
  end

  // slow clock out drops in shutdown, when the always-on domain is off
  // fast source select; slow source; slow clock out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_crystal_osc_sel <= 1'b0;
      slow_crystal_osc_sel <= 1'b0;
      slow_clk_out_en <= 1'b0;
    end else begin
      fast_crystal_osc_sel <= clk_ff[`PMW_CLK_FAST_SEL];
      slow_crystal_osc_sel <= clk_ff[`PMW_CLK_SLOW_SEL];
      slow_clk_out_en <= clk_ff[`PMW_CLK_SLOW_OUT] && state_ff != PMW_SHDN;
    end
  end
endmodule

// ==== design/pmw_defs.svh ====
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH

// register byte offsets
`define PMW_OFF_CTRL 12'h000
`define PMW_OFF_MODE 12'h004
`define PMW_OFF_STAT 12'h008
`define PMW_OFF_MASK 12'h00C
`define PMW_OFF_RCAUSE 12'h010
`define PMW_OFF_CLK 12'h014
`define PMW_OFF_WCFG 12'h018

// control register fields
`define PMW_CTRL_REQ_LSB 0
`define PMW_CTRL_GO_BIT 2

// requested mode codes written to ctrl[1:0]
`define PMW_REQ_IDLE 2'h1
`define PMW_REQ_STBY 2'h2
`define PMW_REQ_SHDN 2'h3

// interrupt status bits
`define PMW_IRQ_ACTIVE 0
`define PMW_IRQ_WAKE_PIN 1
`define PMW_IRQ_WAKE_RTC 2
`define PMW_IRQ_WAKE_SC 3
`define PMW_IRQ_WAKE_INT 4
`define PMW_IRQ_BOD_LOCK 5
`define PMW_IRQ_W 6

// reset cause codes
`define PMW_RC_POR 2'h0
`define PMW_RC_PIN 2'h1
`define PMW_RC_SHDN_WAKE 2'h2

// clock register fields
`define PMW_CLK_FAST_SEL 0
`define PMW_CLK_SLOW_SEL 1
`define PMW_CLK_SLOW_OUT 2
`define PMW_CLK_RST 3'h0

// wake latencies in ns, and cycle counts at 100 ns
`define PMW_CLK_NS 100
`define PMW_T_IDLE_NS 14000
`define PMW_T_STBY_NS 151000
`define PMW_T_SHDN_NS 1015000
`define PMW_CYC_IDLE (`PMW_T_IDLE_NS / `PMW_CLK_NS)
`define PMW_CYC_STBY (`PMW_T_STBY_NS / `PMW_CLK_NS)
`define PMW_CYC_SHDN (`PMW_T_SHDN_NS / `PMW_CLK_NS)
// share of a wake spent on supply and fast clock before cpu release
`define PMW_CYC_CLK_STABLE 16

`endif

// ==== design/pmw_pkg.sv ====
package pmw_pkg;
  typedef enum logic [2:0] {
    PMW_ACTIVE = 3'b000,
    PMW_IDLE = 3'b001,
    PMW_STBY = 3'b010,
    PMW_SHDN = 3'b011,
    PMW_HELD = 3'b100,
    PMW_WAKE = 3'b101
  } pmw_state_e;
  typedef logic [11:0] pmw_addr_t;
endpackage

// ==== tb/pmw_ctrl_asserts.sv ====
`timescale 1ns/100ps
module pmw_ctrl_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // watched pins
  input wire logic reset_pin_n,
  input wire logic fast_clk_stable,
  // gates and status
  input wire logic cpu_clk_en,
  input wire logic mem_clk_en,
  input wire logic periph_clk_en,
  input wire logic radio_clk_en,
  input wire logic flash_pwr_en,
  input wire logic always_on_domain_en,
  input wire logic sensor_ctl_en,
  input wire logic fast_clk_en,
  input wire logic brown_out_detector_en,
  input wire logic core_reset_n,
  input wire logic active_reached
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cpu_only_active: assert property (cpu_clk_en |-> mem_clk_en && core_reset_n && flash_pwr_en)
    else $error("cpu clock outside active");
  a_active_periph_on: assert property (cpu_clk_en |-> periph_clk_en && fast_clk_en)
    else $error("peripheral gate off in active");
  a_idle_mem_off: assert property (periph_clk_en && !cpu_clk_en |-> !mem_clk_en)
    else $error("memory clocked in idle");
  a_shdn_all_off: assert property (!always_on_domain_en |-> !sensor_ctl_en && !fast_clk_en)
    else $error("domain live with always-on off");
  a_shdn_core_rst: assert property (!always_on_domain_en |-> !core_reset_n)
    else $error("core out of reset in shutdown");
  // standby keeps radio and flash off
  a_stby_gates_off: assert property (!fast_clk_en |-> !radio_clk_en && !flash_pwr_en)
    else $error("radio or flash on without fast clock");
  a_stby_bod_off: assert property (sensor_ctl_en && !periph_clk_en |-> !brown_out_detector_en)
    else $error("brown-out detector on in standby");
  a_wake_clk_first: assert property ($rose(cpu_clk_en) |-> $past(fast_clk_stable) && core_reset_n)
    else $error("cpu released before fast clock stable");
  a_held_reset: assert property (!reset_pin_n [*6] |-> !core_reset_n && !cpu_clk_en)
    else $error("core runs while reset pin held");
endmodule
bind pmw_ctrl pmw_ctrl_chk u_chk (.pclk, .presetn, .reset_pin_n, .fast_clk_stable, .cpu_clk_en,
  .mem_clk_en, .periph_clk_en, .radio_clk_en, .flash_pwr_en, .always_on_domain_en,
  .sensor_ctl_en, .fast_clk_en, .brown_out_detector_en, .core_reset_n, .active_reached);

// ==== tb/tb_power_mode_wake_controller.sv ====
`timescale 1ns/100ps
`include "pmw_defs.svh"
module tb_power_mode_wake_controller;
  import pmw_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv;
  pmw_addr_t paddr;
  logic [31:0] pwdata, prdata, rd;
  logic reset_pin_n, rtc_event, sc_event, int_event, bod_low, fast_clk_stable;
  logic [7:0] io_pin_in, io_core_out, io_pin_out;
  logic io_latch_en, cpu_clk_en, mem_clk_en, periph_clk_en, radio_clk_en, flash_pwr_en;
  logic always_on_domain_en, sensor_ctl_en, fast_clk_en, fast_crystal_osc_sel;
  logic slow_crystal_osc_sel, slow_clk_out_en, brown_out_detector_en, core_reset_n;
  logic active_reached;
  int num_errors, comparisons, cyc, n;
  // short wake counts keep the run brief
  pmw_ctrl #(.IO_W(8), .CYC_SHDN(40), .CYC_STBY(30)) dut_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .reset_pin_n,
    .io_pin_in, .rtc_event, .sc_event, .int_event, .bod_low, .fast_clk_stable, .io_core_out,
    .io_pin_out, .io_latch_en, .cpu_clk_en, .mem_clk_en, .periph_clk_en, .radio_clk_en,
    .flash_pwr_en, .always_on_domain_en, .sensor_ctl_en, .fast_clk_en, .fast_crystal_osc_sel,
    .slow_crystal_osc_sel, .slow_clk_out_en, .brown_out_detector_en, .core_reset_n,
    .active_reached);
  // clock
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; called right after a rising edge
  task automatic apb(input logic wr, input pmw_addr_t a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // wait for ready; only the hang guard ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rdc(input pmw_addr_t a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // bounded wait for active; n holds cycles taken
  task automatic wait_act(input int lim);
    n = 0;
    while (active_reached !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, active_reached}, 32'h1);
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    reset_pin_n = 1; rtc_event = 0; sc_event = 0; int_event = 0; bod_low = 0;
    fast_clk_stable = 1; io_pin_in = 8'h00; io_core_out = 8'hA5;
    num_errors = 0; comparisons = 0; cyc = 0; presetn = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    // power-on boot and register access
    wait_act(300);
    rdc(`PMW_OFF_RCAUSE, {30'h0, `PMW_RC_POR});
    apb(1'b1, `PMW_OFF_CLK, 32'h7);
    rdc(`PMW_OFF_CLK, 32'h7);
    chk({29'h0, slow_clk_out_en, slow_crystal_osc_sel, fast_crystal_osc_sel}, 32'h7);
    apb(1'b0, 12'h01C, 32'h0);
    chk({31'h0, slv}, 32'h1);
    apb(1'b1, `PMW_OFF_MASK, 32'h10);
    // idle: interrupt wakes after the short latency
    apb(1'b1, `PMW_OFF_CTRL, 32'h5);
    rdc(`PMW_OFF_MODE, 32'h1);
    chk({30'h0, cpu_clk_en, periph_clk_en}, 32'h1);
    int_event <= 1;
    wait_act(400);
    chk(n >= `PMW_CYC_IDLE && n <= `PMW_CYC_IDLE + 20, 32'h1);
    int_event <= 0;
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `PMW_OFF_STAT, 32'h3F);
    chk({31'h0, irq}, 32'h0);
    // standby: pins latched, interrupt ignored, rtc wakes
    apb(1'b1, `PMW_OFF_CTRL, 32'h6);
    io_core_out <= 8'h3C;
    int_event <= 1;
    repeat (20) @(posedge pclk);
    chk(io_pin_out, 8'hA5);
    chk({31'h0, io_latch_en}, 32'h1);
    chk({28'h0, always_on_domain_en, sensor_ctl_en, fast_clk_en, cpu_clk_en}, 32'hC);
    rdc(`PMW_OFF_MODE, 32'h2);
    int_event <= 0;
    rtc_event <= 1;
    wait_act(200);
    chk(n >= 30 && n <= 50, 32'h1);
    chk({31'h0, core_reset_n}, 32'h1);
    rtc_event <= 0;
    rdc(`PMW_OFF_MASK, 32'h10);
    // shutdown: rtc ignored, enabled pin change wakes through reset
    apb(1'b1, `PMW_OFF_WCFG, 32'h1);
    apb(1'b1, `PMW_OFF_CTRL, 32'h7);
    io_core_out <= 8'h0F;
    rtc_event <= 1;
    repeat (30) @(posedge pclk);
    chk({30'h0, always_on_domain_en, core_reset_n}, 32'h0);
    chk(io_pin_out, 8'h3C);
    chk({31'h0, active_reached}, 32'h0);
    rtc_event <= 0;
    io_pin_in <= 8'h01;
    wait_act(200);
    chk(n >= 40 && n <= 70, 32'h1);
    rdc(`PMW_OFF_RCAUSE, {30'h0, `PMW_RC_SHDN_WAKE});
    rdc(`PMW_OFF_MASK, 32'h0);
    // brown-out lock in standby, freed by reset pin
    apb(1'b1, `PMW_OFF_CTRL, 32'h6);
    bod_low <= 1;
    repeat (5) @(posedge pclk);
    bod_low <= 0;
    sc_event <= 1;
    repeat (80) @(posedge pclk);
    chk({31'h0, active_reached}, 32'h0);
    sc_event <= 0;
    reset_pin_n <= 0;
    repeat (8) @(posedge pclk);
    rdc(`PMW_OFF_MODE, 32'h4);
    reset_pin_n <= 1;
    // fast clock late: the wake must stall with the core held
    fast_clk_stable <= 0;
    repeat (60) @(posedge pclk);
    chk({30'h0, core_reset_n, active_reached}, 32'h0);
    fast_clk_stable <= 1;
    wait_act(200);
    rdc(`PMW_OFF_RCAUSE, {30'h0, `PMW_RC_PIN});
    print_verdict();
  end
endmodule
